// File: cpa_regs.sv
// Coprocessor access control, delegation and media register permissions
`timescale 1ns/1ps
module cpa_regs #(
    // Arbitrary identification value
    parameter logic [31:0] FP_IDENT = 32'h5A00_0001
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_secure,
    input  wire logic        req_priv,
    input  wire logic        req_sys,
    input  wire logic [2:0]  req_opc1,
    input  wire logic [3:0]  req_crn,
    input  wire logic [3:0]  req_crm,
    input  wire logic [2:0]  req_opc2,
    input  wire logic        req_fp,
    input  wire logic [3:0]  req_fp_reg,
    input  wire logic [31:0] req_wdata,
    input  wire logic        instr_sync_barrier,
    output logic             rsp_valid,
    output logic             rsp_undef,
    output logic [31:0]      rsp_rdata,
    output logic [1:0]       fp_coproc_a_perm,
    output logic [1:0]       fp_coproc_b_perm,
    output logic             fp_coproc_a_nonsecure,
    output logic             fp_coproc_b_nonsecure,
    output logic             vector_ext_disable_s,
    output logic             vector_ext_disable_ns,
    output logic             upper_bank_disable_s,
    output logic             upper_bank_disable_ns,
    output logic             fp_unit_enable,
    output logic             access_sync_pending
);
    import cpa_pkg::*;

    typedef enum logic [1:0] {
        SYNC_CLEAN   = 2'b01,
        SYNC_PENDING = 2'b10
    } cpa_sync_t;

    cpa_acc_if acc ();

    // Live access control fields
    logic       vec_dis_reg;
    logic       upper_dis_reg;
    logic [1:0] cpa_perm_reg;
    logic [1:0] cpb_perm_reg;
    // Delegation fields
    logic       vec_lock_reg;
    logic       upper_lock_reg;
    logic       ns_a_reg;
    logic       ns_b_reg;
    // Copies the pipeline sees, refreshed at each barrier
    logic       eff_vec_dis_reg;
    logic       eff_upper_dis_reg;
    logic [1:0] eff_cpa_perm_reg;
    logic [1:0] eff_cpb_perm_reg;

    cpa_sync_t   sync_reg;
    cpa_sync_t   sync_next;

    logic        rsp_valid_reg;
    logic        rsp_undef_reg;
    logic [31:0] rsp_rdata_reg;

    logic        sel_match;
    logic        sel_access;
    logic        sel_delegate;
    logic        sel_other;
    logic        fp_go;
    logic        access_refused;
    logic        delegate_refused;
    logic        access_wr;
    logic        delegate_wr;
    logic        undef_now;
    logic [31:0] access_view;
    logic [31:0] delegate_view;
    logic [31:0] rdata_now;

    // Decode of the system coprocessor selector
    assign sel_match    = req_valid && req_sys && req_opc1 == SEL_OPC1 &&
                          req_crn == SEL_CRN && req_opc2 == SEL_OPC2;
    assign sel_access   = sel_match && req_crm == SEL_CRM_ACCESS;
    assign sel_delegate = sel_match && req_crm == SEL_CRM_DELEGATE;
    assign sel_other    = req_valid && req_sys && !sel_access &&
                          !sel_delegate;
    assign fp_go        = req_valid && req_fp && !req_sys;

    // Mode is taken from the request of this very cycle
    assign access_refused   = !req_priv;
    assign delegate_refused = !req_priv || (!req_secure && req_write);

    assign access_wr   = sel_access && req_write && !access_refused;
    assign delegate_wr = sel_delegate && req_write && !delegate_refused;

    // Media transfers go through the permission and bank modules
    assign acc.priv     = req_priv;
    assign acc.secure   = req_secure;
    assign acc.write    = req_write;
    assign acc.wdata    = req_wdata;
    assign acc.fp_reg   = req_fp_reg;
    assign acc.fp_req   = fp_go;
    // Media checks use the post-barrier copy, as the pipeline does
    assign acc.cpa_perm = eff_cpa_perm_reg;
    assign acc.cpb_perm = eff_cpb_perm_reg;
    assign acc.ns_a     = ns_a_reg;
    assign acc.ns_b     = ns_b_reg;

    cpa_perm_check u_check (
        .acc (acc.check)
    );

    cpa_fp_bank #(
        .FP_IDENT (FP_IDENT)
    ) u_bank (
        .mclk (mclk),
        .rst  (rst),
        .acc  (acc.bank)
    );

    // Secure privileged: all fields. Non-secure privileged: per delegation.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cpa_perm_reg <= ACC_RST[ACC_CPA_LSB +: 2];
            cpb_perm_reg <= ACC_RST[ACC_CPB_LSB +: 2];
        end else if (access_wr) begin
            if (req_secure || ns_a_reg) begin
                cpa_perm_reg <= req_wdata[ACC_CPA_LSB +: 2];
            end
            if (req_secure || ns_b_reg) begin
                cpb_perm_reg <= req_wdata[ACC_CPB_LSB +: 2];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            vec_dis_reg   <= ACC_RST[ACC_VEC_DIS_BIT];
            upper_dis_reg <= ACC_RST[ACC_UPPER_DIS_BIT];
        end else if (access_wr) begin
            if (req_secure || !vec_lock_reg) begin
                vec_dis_reg <= req_wdata[ACC_VEC_DIS_BIT];
            end
            if (req_secure || !upper_lock_reg) begin
                upper_dis_reg <= req_wdata[ACC_UPPER_DIS_BIT];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            vec_lock_reg   <= DLG_RST[DLG_VEC_LOCK_BIT];
            upper_lock_reg <= DLG_RST[DLG_UPPER_LOCK_BIT];
            ns_a_reg       <= DLG_RST[DLG_CPA_BIT];
            ns_b_reg       <= DLG_RST[DLG_CPB_BIT];
        end else if (delegate_wr) begin
            vec_lock_reg   <= req_wdata[DLG_VEC_LOCK_BIT];
            upper_lock_reg <= req_wdata[DLG_UPPER_LOCK_BIT];
            ns_a_reg       <= req_wdata[DLG_CPA_BIT];
            ns_b_reg       <= req_wdata[DLG_CPB_BIT];
        end
    end

    // Barrier copies the live value; a write in the same cycle
    // lands in the live register and waits for the next barrier
    always_ff @(posedge mclk) begin
        if (rst) begin
            eff_vec_dis_reg   <= ACC_RST[ACC_VEC_DIS_BIT];
            eff_upper_dis_reg <= ACC_RST[ACC_UPPER_DIS_BIT];
            eff_cpa_perm_reg  <= ACC_RST[ACC_CPA_LSB +: 2];
            eff_cpb_perm_reg  <= ACC_RST[ACC_CPB_LSB +: 2];
        end else if (instr_sync_barrier) begin
            eff_vec_dis_reg   <= vec_dis_reg;
            eff_upper_dis_reg <= upper_dis_reg;
            eff_cpa_perm_reg  <= cpa_perm_reg;
            eff_cpb_perm_reg  <= cpb_perm_reg;
        end
    end

    // Tracks a write not yet made visible; write wins over barrier
    always_comb begin
        sync_next = sync_reg;
        unique case (sync_reg)
            SYNC_CLEAN: begin
                if (access_wr) begin
                    sync_next = SYNC_PENDING;
                end
            end
            SYNC_PENDING: begin
                if (instr_sync_barrier && !access_wr) begin
                    sync_next = SYNC_CLEAN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_reg <= SYNC_CLEAN;
        end else begin
            sync_reg <= sync_next;
        end
    end

    // Read views seen by the requesting state
    always_comb begin
        access_view = 32'h0000_0000;
        access_view[ACC_VEC_DIS_BIT] = vec_dis_reg ||
                                       (!req_secure && vec_lock_reg);
        access_view[ACC_UPPER_DIS_BIT] = upper_dis_reg ||
                                         (!req_secure && upper_lock_reg);
        if (req_secure || ns_a_reg) begin
            access_view[ACC_CPA_LSB +: 2] = cpa_perm_reg;
        end
        if (req_secure || ns_b_reg) begin
            access_view[ACC_CPB_LSB +: 2] = cpb_perm_reg;
        end
    end

    always_comb begin
        delegate_view = 32'h0000_0000;
        delegate_view[DLG_VEC_LOCK_BIT]   = vec_lock_reg;
        delegate_view[DLG_UPPER_LOCK_BIT] = upper_lock_reg;
        delegate_view[DLG_CPA_BIT]        = ns_a_reg;
        delegate_view[DLG_CPB_BIT]        = ns_b_reg;
    end

    // One undefined flag per refused instruction, read data forced to zero
    always_comb begin
        undef_now = 1'b0;
        rdata_now = 32'h0000_0000;
        if (sel_access) begin
            undef_now = access_refused;
            if (!access_refused && !req_write) begin
                rdata_now = access_view;
            end
        end else if (sel_delegate) begin
            undef_now = delegate_refused;
            if (!delegate_refused && !req_write) begin
                rdata_now = delegate_view;
            end
        end else if (fp_go) begin
            undef_now = !acc.fp_allowed;
            if (acc.fp_allowed && !req_write) begin
                rdata_now = acc.fp_rdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp_valid_reg <= 1'b0;
            rsp_undef_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= sel_access || sel_delegate || sel_other ||
                             fp_go;
            rsp_undef_reg <= undef_now;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp_rdata_reg <= 32'h0000_0000;
        end else begin
            rsp_rdata_reg <= rdata_now;
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_undef = rsp_undef_reg;
    assign rsp_rdata = rsp_rdata_reg;

    // Pipeline view; non-secure state sees locked disable bits as one
    assign fp_coproc_a_perm      = eff_cpa_perm_reg;
    assign fp_coproc_b_perm      = eff_cpb_perm_reg;
    assign fp_coproc_a_nonsecure = ns_a_reg;
    assign fp_coproc_b_nonsecure = ns_b_reg;
    assign vector_ext_disable_s  = eff_vec_dis_reg;
    assign vector_ext_disable_ns = eff_vec_dis_reg || vec_lock_reg;
    assign upper_bank_disable_s  = eff_upper_dis_reg;
    assign upper_bank_disable_ns = eff_upper_dis_reg || upper_lock_reg;
    assign fp_unit_enable        = acc.unit_en;
    assign access_sync_pending   = sync_reg == SYNC_PENDING;

endmodule

// File: cpa_pkg.sv
// Shared constants and helpers for the coprocessor access permission block
// Functional notes
// - Secure privileged reads/writes permission fields; non-secure follows delegation bit.
// - Any user-mode access to the access control register raises undefined.
// - Non-secure coprocessor use also needs the delegation register permission.
// - Access control changes reach the pipeline only after the next barrier.
// - Delegation register: secure privileged read/write, non-secure privileged read-only.
// - Non-secure privileged write or any user access to delegation raises undefined.
// - Delegation bit 15 set: vector disable reads one, ignores non-secure writes.
// - Delegation bit 14 set: upper bank disable reads one, ignores non-secure writes.
// - Delegation bits 11 and 10 allow non-secure media coprocessor use; reset zero.
// - Access control register selected by opcode1 0, c1, c0, opcode2 2.
// - Delegation register selected by opcode1 0, c1, c1, opcode2 2.
// - Media registers are 32 bits; reserved numbers read zero, ignore writes.
// - Status and control register is read/write, resets to zero.
// - Exception register is read/write, resets to zero.
// - Feature registers are constants 0x01111111 and 0x10110222.
// - Identification register is read-only, fixed implementation value.
// - Status and control register accessible in any mode only when unit enabled.
// - Ident, feature and exception registers: privileged always, user never.
// - Permission field: 00 denied, 01 privileged, 11 privileged and user, 10 reserved.
// - Access control register resets to zero, media coprocessors denied.
package cpa_pkg;

    // System coprocessor selector fields
    localparam logic [2:0] SEL_OPC1          = 3'h0;
    localparam logic [3:0] SEL_CRN           = 4'h1;
    localparam logic [3:0] SEL_CRM_ACCESS    = 4'h0;
    localparam logic [3:0] SEL_CRM_DELEGATE  = 4'h1;
    localparam logic [2:0] SEL_OPC2          = 3'h2;

    // Access control register fields
    localparam int ACC_VEC_DIS_BIT   = 31;
    localparam int ACC_UPPER_DIS_BIT = 30;
    localparam int ACC_CPB_LSB       = 22;
    localparam int ACC_CPA_LSB       = 20;
    localparam logic [31:0] ACC_RST  = 32'h0000_0000;

    // Delegation register fields
    localparam int DLG_VEC_LOCK_BIT   = 15;
    localparam int DLG_UPPER_LOCK_BIT = 14;
    localparam int DLG_CPB_BIT        = 11;
    localparam int DLG_CPA_BIT        = 10;
    localparam logic [31:0] DLG_RST   = 32'h0000_0000;

    // Permission field codes
    localparam logic [1:0] PERM_DENIED = 2'h0;
    localparam logic [1:0] PERM_PRIV   = 2'h1;
    localparam logic [1:0] PERM_FULL   = 2'h3;

    // Media register numbers
    localparam logic [3:0] FP_REG_IDENT  = 4'h0;
    localparam logic [3:0] FP_REG_STATUS = 4'h1;
    localparam logic [3:0] FP_REG_FEAT1  = 4'h6;
    localparam logic [3:0] FP_REG_FEAT0  = 4'h7;
    localparam logic [3:0] FP_REG_EXC    = 4'h8;

    localparam logic [31:0] FP_STATUS_RST  = 32'h0000_0000;
    localparam logic [31:0] FP_EXC_RST     = 32'h0000_0000;
    localparam logic [31:0] MEDIA_FEAT1_VAL = 32'h0111_1111;
    localparam logic [31:0] MEDIA_FEAT0_VAL = 32'h1011_0222;
    localparam int          FP_EXC_EN_BIT  = 30;

    // Field grants the mode; reserved and denied codes grant nothing
    function automatic logic perm_allows(input logic [1:0] perm,
                                         input logic       priv);
        perm_allows = (perm == PERM_FULL) || (priv && perm == PERM_PRIV);
    endfunction

endpackage

// File: cpa_acc_if.sv
// Carrier between the top and its permission and media register modules
`timescale 1ns/1ps
interface cpa_acc_if;
    logic        priv;
    logic        secure;
    logic        write;
    logic [31:0] wdata;
    logic [3:0]  fp_reg;
    logic        fp_req;
    logic [1:0]  cpa_perm;
    logic [1:0]  cpb_perm;
    logic        ns_a;
    logic        ns_b;
    logic        fp_allowed;
    logic [31:0] fp_rdata;
    logic        unit_en;

    modport top   (output priv, secure, write, wdata, fp_reg, fp_req,
                   cpa_perm, cpb_perm, ns_a, ns_b,
                   input fp_allowed, fp_rdata, unit_en);
    modport check (input priv, secure, fp_reg, cpa_perm, cpb_perm,
                   ns_a, ns_b, unit_en, output fp_allowed);
    modport bank  (input write, wdata, fp_reg, fp_req, fp_allowed,
                   output fp_rdata, unit_en);
endinterface

// File: cpa_perm_check.sv
// Permission decision for media system register transfers
`timescale 1ns/1ps
module cpa_perm_check (
    cpa_acc_if.check acc
);
    import cpa_pkg::*;

    logic coproc_ok;
    logic reg_ok;

    always_comb begin
        // Both coprocessor numbers must grant the mode
        coproc_ok = perm_allows(acc.cpa_perm, acc.priv) &&
                    perm_allows(acc.cpb_perm, acc.priv);
        if (!acc.secure) begin
            coproc_ok = coproc_ok && acc.ns_a && acc.ns_b;
        end
        unique case (acc.fp_reg)
            FP_REG_STATUS: reg_ok = acc.unit_en;
            FP_REG_IDENT,
            FP_REG_FEAT1,
            FP_REG_FEAT0,
            FP_REG_EXC:    reg_ok = acc.priv;
            // Reserved numbers answer as zero rather than trap
            default:       reg_ok = 1'b1;
        endcase
    end

    assign acc.fp_allowed = coproc_ok && reg_ok;

endmodule

// File: cpa_fp_bank.sv
// Media system register bank: two stored registers and three constants
`timescale 1ns/1ps
module cpa_fp_bank #(
    // Arbitrary identification value
    parameter logic [31:0] FP_IDENT = 32'h5A00_0001
) (
    input  wire logic mclk,
    input  wire logic rst,
    cpa_acc_if.bank   acc
);
    import cpa_pkg::*;

    logic [31:0] fp_status_control_reg;
    logic [31:0] fp_exception_ctrl_reg;
    logic        wr_ok;

    // Refused writes never reach the storage
    assign wr_ok = acc.fp_req && acc.fp_allowed && acc.write;

    always_ff @(posedge mclk) begin
        if (rst) begin
            fp_status_control_reg <= FP_STATUS_RST;
        end else if (wr_ok && acc.fp_reg == FP_REG_STATUS) begin
            fp_status_control_reg <= acc.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            fp_exception_ctrl_reg <= FP_EXC_RST;
        end else if (wr_ok && acc.fp_reg == FP_REG_EXC) begin
            fp_exception_ctrl_reg <= acc.wdata;
        end
    end

    assign acc.unit_en = fp_exception_ctrl_reg[FP_EXC_EN_BIT];

    always_comb begin
        unique case (acc.fp_reg)
            FP_REG_IDENT:  acc.fp_rdata = FP_IDENT;
            FP_REG_STATUS: acc.fp_rdata = fp_status_control_reg;
            FP_REG_FEAT1:  acc.fp_rdata = MEDIA_FEAT1_VAL;
            FP_REG_FEAT0:  acc.fp_rdata = MEDIA_FEAT0_VAL;
            FP_REG_EXC:    acc.fp_rdata = fp_exception_ctrl_reg;
            default:       acc.fp_rdata = 32'h0000_0000;
        endcase
    end

endmodule

// File: cpa_regs_properties.sv
// Port-level properties of the coprocessor permission block
`timescale 1ns/1ps
module cpa_regs_properties (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic        req_secure,
    input wire logic        req_priv,
    input wire logic        req_sys,
    input wire logic [2:0]  req_opc1,
    input wire logic [3:0]  req_crn,
    input wire logic [3:0]  req_crm,
    input wire logic [2:0]  req_opc2,
    input wire logic        req_fp,
    input wire logic [3:0]  req_fp_reg,
    input wire logic        instr_sync_barrier,
    input wire logic        rsp_valid,
    input wire logic        rsp_undef,
    input wire logic [31:0] rsp_rdata,
    input wire logic [1:0]  fp_coproc_a_perm,
    input wire logic [1:0]  fp_coproc_b_perm,
    input wire logic        fp_coproc_a_nonsecure,
    input wire logic        fp_coproc_b_nonsecure,
    input wire logic        vector_ext_disable_s,
    input wire logic        vector_ext_disable_ns,
    input wire logic        fp_unit_enable,
    input wire logic        access_sync_pending
);
    import cpa_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic sys_hit;
    assign sys_hit = req_valid && req_sys && req_opc1 == SEL_OPC1
                     && req_crn == SEL_CRN && req_opc2 == SEL_OPC2;
    sequence s_acc; sys_hit && req_crm == SEL_CRM_ACCESS; endsequence
    sequence s_dlg; sys_hit && req_crm == SEL_CRM_DELEGATE; endsequence
    sequence s_fp; req_valid && !req_sys && req_fp; endsequence
    sequence s_set; s_acc ##0 req_write && req_secure && req_priv; endsequence
    // A write in the barrier cycle keeps the sync pending
    sequence s_isb; instr_sync_barrier
        && !(sys_hit && req_crm == SEL_CRM_ACCESS && req_write); endsequence

    AST_RSP_TIME: assert property (s_fp or s_acc |=> rsp_valid)
        else $error("answer missing");
    AST_UNDEF_RAZ: assert property (
        rsp_valid && rsp_undef |-> rsp_rdata == 32'h0)
        else $error("undef with read data");
    AST_ACC_USER: assert property (s_acc ##0 !req_priv |=> rsp_undef)
        else $error("user access not refused");
    AST_DLG_REFUSE: assert property (
        s_dlg ##0 (!req_priv || req_write && !req_secure) |=> rsp_undef)
        else $error("delegation not refused");
    AST_DLG_OK: assert property (
        s_dlg ##0 req_priv && req_secure |=> !rsp_undef)
        else $error("secure delegation refused");
    AST_PEND_SET: assert property (s_set |=> access_sync_pending)
        else $error("pending not raised");
    AST_PEND_CLR: assert property (s_isb |=> !access_sync_pending)
        else $error("pending not cleared");
    AST_PERM_ISB: assert property (!$past(rst) && (
        $changed(fp_coproc_a_perm) || $changed(fp_coproc_b_perm))
        |-> $past(instr_sync_barrier))
        else $error("perm moved without barrier");
    AST_VEC_LOCK: assert property (
        vector_ext_disable_s |-> vector_ext_disable_ns)
        else $error("non-secure view lost");
    AST_FP_DENY: assert property (s_fp ##0 (
        fp_coproc_a_perm == PERM_DENIED || fp_coproc_b_perm == PERM_DENIED)
        |=> rsp_undef) else $error("denied coprocessor answered");
    AST_FP_NS: assert property (s_fp ##0 !req_secure && !(
        fp_coproc_a_nonsecure && fp_coproc_b_nonsecure) |=> rsp_undef)
        else $error("non-secure media not refused");
    AST_FP_EN: assert property (s_fp ##0
        req_fp_reg == FP_REG_STATUS && !fp_unit_enable |=> rsp_undef)
        else $error("status while unit off");
endmodule

bind cpa_regs cpa_regs_properties chk (.*);

// File: cpa_core_model.sv
// Core issue pipeline model that sends coprocessor transfers
`timescale 1ns/1ps
module cpa_core_model (
    input  wire logic        mclk,
    output logic             req_valid,
    output logic             req_write,
    output logic             req_secure,
    output logic             req_priv,
    output logic             req_sys,
    output logic [2:0]       req_opc1,
    output logic [3:0]       req_crn,
    output logic [3:0]       req_crm,
    output logic [2:0]       req_opc2,
    output logic             req_fp,
    output logic [3:0]       req_fp_reg,
    output logic [31:0]      req_wdata,
    output logic             instr_sync_barrier,
    input  wire logic        rsp_valid,
    input  wire logic        rsp_undef,
    input  wire logic [31:0] rsp_rdata
);
    initial begin
        {req_valid, req_write, req_secure, req_priv, req_sys} = 5'h00;
        {req_opc1, req_crn} = {3'h0, 4'h1};
        {req_crm, req_opc2, req_fp, req_fp_reg} = 12'h000;
        {req_wdata, instr_sync_barrier} = 33'h0;
    end

    // Mode travels with the request, never ahead of it
    task automatic xfer(input logic sys, wr, sec, pv,
                        input logic [3:0] sel, input logic [2:0] o2,
                        input logic [31:0] wd, output logic ok, und,
                        output logic [31:0] rd);
        @(negedge mclk);
        {req_sys, req_fp, req_write} = {sys, !sys, wr};
        {req_secure, req_priv} = {sec, pv};
        {req_crm, req_fp_reg, req_opc2} = {sel, sel, o2};
        req_wdata = wd;
        req_valid = 1'h1;
        @(negedge mclk);
        req_valid = 1'h0;
        {ok, und, rd} = {rsp_valid, rsp_undef, rsp_rdata};
    endtask

    // Read first so fields of other coprocessors survive
    task automatic rmw(input logic sec, pv, input logic [31:0] mask, val);
        logic        ok;
        logic        und;
        logic [31:0] rd;
        xfer(1'h1, 1'h0, sec, pv, 4'h0, 3'h2, 32'h0, ok, und, rd);
        xfer(1'h1, 1'h1, sec, pv, 4'h0, 3'h2, (rd & ~mask) | val,
             ok, und, rd);
    endtask

    // Callers hold dependent transfers until this returns
    task automatic barrier();
        @(negedge mclk);
        instr_sync_barrier = 1'h1;
        @(negedge mclk);
        instr_sync_barrier = 1'h0;
    endtask
endmodule

// File: cpa_regs_tb_top.sv
// Self-checking bench for the coprocessor permission block
`timescale 1ns/1ps
module cpa_regs_tb_top;
    import cpa_pkg::*;
    // Arbitrary identification value
    localparam logic [31:0] IDV = 32'h3C00_00A5;
    localparam logic        HI  = 1'h1;
    localparam logic        LO  = 1'h0;
    logic        mclk, rst, req_valid, req_write, req_secure, req_priv;
    logic        req_sys, req_fp, instr_sync_barrier, rsp_valid, rsp_undef;
    logic [2:0]  req_opc1, req_opc2;
    logic [3:0]  req_crn, req_crm, req_fp_reg;
    logic [31:0] req_wdata, rsp_rdata, r;
    logic [1:0]  fp_coproc_a_perm, fp_coproc_b_perm;
    logic        fp_coproc_a_nonsecure, fp_coproc_b_nonsecure;
    logic        vector_ext_disable_s, vector_ext_disable_ns;
    logic        upper_bank_disable_s, upper_bank_disable_ns;
    logic        fp_unit_enable, access_sync_pending, ok, u;
    int          err_count = 0;
    int          n_tests   = 0;
    int          cyc       = 0;

    cpa_regs #(.FP_IDENT(IDV)) DUT (.*);
    cpa_core_model core (.*);

    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Run is about 95 cycles; a hang stops far beyond that
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_count++;
            results();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask

    task automatic flag(input string nm, input logic seen, exp);
        check(nm, {31'h0, seen}, {31'h0, exp});
    endtask

    task automatic acc(input logic s, w, sc, p, input logic [3:0] sel,
                       input logic [31:0] wd, input logic eu,
                       input logic [31:0] er);
        core.xfer(s, w, sc, p, sel, 3'h2, wd, ok, u, r);
        flag("rsp_valid", ok, HI);
        flag("rsp_undef", u, eu);
        check("rsp_rdata", r, er);
    endtask

    initial begin
        rst = 1'h1;
        repeat (10) @(negedge mclk);
        rst = 1'h0;
        acc(HI,LO,HI,HI,4'h0,32'h0,LO,32'h0);
        acc(HI,LO,HI,HI,4'h1,32'h0,LO,32'h0);
        acc(LO,LO,HI,HI,FP_REG_EXC,32'h0,HI,32'h0);
        $display("test reset done");
        acc(HI,LO,HI,LO,4'h0,32'h0,HI,32'h0);
        acc(HI,HI,LO,LO,4'h0,32'h00F0_0000,HI,32'h0);
        acc(HI,LO,LO,LO,4'h1,32'h0,HI,32'h0);
        acc(HI,HI,LO,HI,4'h1,32'h0C00,HI,32'h0);
        acc(HI,LO,HI,HI,4'h0,32'h0,LO,32'h0);
        $display("test user refusal done");
        acc(HI,HI,HI,HI,4'h1,32'hC000,LO,32'h0);
        acc(HI,LO,LO,HI,4'h1,32'h0,LO,32'hC000);
        acc(HI,HI,LO,HI,4'h0,32'hFFFF_FFFF,LO,32'h0);
        acc(HI,LO,LO,HI,4'h0,32'h0,LO,32'hC000_0000);
        acc(HI,LO,HI,HI,4'h0,32'h0,LO,32'h0);
        flag("vec_ns", vector_ext_disable_ns, HI);
        flag("up_ns", upper_bank_disable_ns, HI);
        $display("test delegation locks done");
        core.rmw(HI,HI,32'hC0F0_0000,32'hC0F0_0000);
        flag("pending", access_sync_pending, HI);
        check("a_perm", {30'h0,fp_coproc_a_perm}, 32'h0);
        core.barrier();
        check("a_perm", {30'h0,fp_coproc_a_perm}, 32'h3);
        check("b_perm", {30'h0,fp_coproc_b_perm}, 32'h3);
        flag("pending", access_sync_pending, LO);
        flag("vec_s", vector_ext_disable_s, HI);
        flag("up_s", upper_bank_disable_s, HI);
        acc(HI,LO,HI,HI,4'h0,32'h0,LO,32'hC0F0_0000);
        $display("test barrier done");
        acc(LO,LO,HI,HI,FP_REG_IDENT,32'h0,LO,IDV);
        acc(LO,LO,HI,HI,FP_REG_FEAT1,32'h0,LO,32'h0111_1111);
        acc(LO,LO,HI,HI,FP_REG_FEAT0,32'h0,LO,32'h1011_0222);
        acc(LO,LO,HI,HI,FP_REG_EXC,32'h0,LO,32'h0);
        acc(LO,LO,HI,HI,FP_REG_STATUS,32'h0,HI,32'h0);
        acc(LO,HI,HI,LO,FP_REG_EXC,32'h4000_0000,HI,32'h0);
        acc(LO,LO,HI,HI,FP_REG_EXC,32'h0,LO,32'h0);
        acc(LO,HI,HI,HI,FP_REG_EXC,32'h4000_0000,LO,32'h0);
        flag("unit_en", fp_unit_enable, HI);
        acc(LO,HI,HI,HI,FP_REG_STATUS,32'h1234_5678,LO,32'h0);
        acc(LO,LO,HI,LO,FP_REG_STATUS,32'h0,LO,32'h1234_5678);
        acc(LO,LO,HI,LO,FP_REG_IDENT,32'h0,HI,32'h0);
        acc(LO,HI,HI,HI,4'h3,32'hFFFF_FFFF,LO,32'h0);
        acc(LO,LO,HI,HI,4'h3,32'h0,LO,32'h0);
        $display("test media registers done");
        acc(LO,LO,LO,HI,FP_REG_FEAT0,32'h0,HI,32'h0);
        acc(HI,HI,HI,HI,4'h1,32'hCC00,LO,32'h0);
        flag("a_ns", fp_coproc_a_nonsecure, HI);
        flag("b_ns", fp_coproc_b_nonsecure, HI);
        acc(LO,LO,LO,HI,FP_REG_FEAT0,32'h0,LO,32'h1011_0222);
        acc(HI,HI,LO,HI,4'h0,32'h0050_0000,LO,32'h0);
        acc(HI,LO,LO,HI,4'h0,32'h0,LO,32'hC050_0000);
        core.barrier();
        acc(LO,LO,HI,LO,FP_REG_STATUS,32'h0,HI,32'h0);
        acc(LO,LO,HI,HI,FP_REG_STATUS,32'h0,LO,32'h1234_5678);
        acc(HI,HI,HI,HI,4'h0,32'h00A0_0000,LO,32'h0);
        core.barrier();
        acc(LO,LO,HI,HI,FP_REG_STATUS,32'h0,HI,32'h0);
        $display("test non-secure and codes done");
        core.xfer(HI,LO,HI,HI,4'h0,3'h3,32'h0,ok,u,r);
        flag("odd_valid", ok, HI);
        flag("odd_undef", u, LO);
        check("odd_rdata", r, 32'h0);
        $display("test foreign selector done");
        results();
    end
endmodule
